// *** bench/hesx_exec_checker.sv ***
`timescale 1ns/1ns
// ****************************************
// Port checker for the execution block
// ****************************************
module hesx_exec_checker
  import hesx_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Run state
  input wire logic        halted
);
  logic wr;      // Completed write
  logic wr_ins;  // Instruction accepted while running
  logic restart; // Restart request
  logic sel_ff;  // Mirror of the selective-stop switch

  assign wr      = psel && penable && pready && pwrite;
  assign wr_ins  = wr && paddr == OFF_INSTR && !halted;
  assign restart = wr && paddr == OFF_CTRL && pwdata[CTRL_RESTART_BIT];

  // Switch mirror, so a stop outcome can be predicted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sel_ff <= 1'b0;
    else if (wr && paddr == OFF_CTRL) sel_ff <= pwdata[CTRL_SEL_STOP_BIT];
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************
  // Bus timing and error response
  // ****************************************
  a_ready_follows: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside one access cycle");
  a_err_unmapped: assert property (pready && paddr > OFF_IDX3 |-> pslverr)
    else $error("unmapped access without pslverr");

  // ****************************************
  // Stopping and restart
  // ****************************************
  a_halt_stops: assert property (
    wr_ins && pwdata[OPC_HI:OPC_LO] == OP_HALT
    && pwdata[SUB_HI:SUB_LO] == SUB_ZERO |=> halted)
    else $error("halt did not stop");
  a_stop_always: assert property (
    wr_ins && pwdata[OPC_HI:OPC_LO] == OP_MISC
    && pwdata[STOP_HI:STOP_LO] == STOP_UNC |=> halted)
    else $error("unconditional stop did not stop");
  a_sel_stop: assert property (
    wr_ins && pwdata[OPC_HI:OPC_LO] == OP_MISC
    && pwdata[STOP_HI:STOP_LO] == STOP_SEL |=> halted == $past(sel_ff))
    else $error("selective stop ignored the switch");
  a_halt_cause: assert property ($rose(halted) |-> $past(wr_ins))
    else $error("halt without an instruction");
  a_halt_hold: assert property (halted && !restart |=> halted)
    else $error("halt released without restart");
  a_restart_runs: assert property (restart |=> !halted)
    else $error("restart did not resume");
endmodule : hesx_exec_checker

bind hesx_exec hesx_exec_checker chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .halted(halted)
);

// *** bench/hesx_seq_model.sv ***
`timescale 1ns/1ns
// ****************************************
// Fetch sequencer and console, as APB master
// ****************************************
module hesx_seq_model (
  // Clock
  input  wire logic        pclk,
  // Requests
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // Answers
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // One transfer; entered and left just after a rising edge
  task xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    int n;
    logic to;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= we;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Bounded wait for the slave's answer
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    // Loop left without an answer: the slave never became ready
    to = (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data no longer shows the old word
    pwdata  <= ~d;
    @(posedge pclk);
    if (to) begin
      test_halt_enter_increase_skip_exec.failures++;
      test_halt_enter_increase_skip_exec.wrap_up();
    end
  endtask : xfer
endmodule : hesx_seq_model

// *** bench/test_halt_enter_increase_skip_exec.sv ***
`timescale 1ns/1ns
module test_halt_enter_increase_skip_exec
  import hesx_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, halted;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          failures, n_compared, seed;
  logic [23:0] ra, rq, w;   // Expected A, Q; instruction
  logic [14:0] rp, y;       // Expected P; immediate
  logic [14:0] rx [1:3];    // Expected index registers
  logic [5:0]  ops [6];     // Operation codes swept

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  hesx_exec uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .halted(halted));
  hesx_seq_model seq (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // ****************************************
  // Expectation helpers
  // ****************************************
  function automatic logic [23:0] sx15(input logic [14:0] v);
    return {{9{v[IMM_SIGN]}}, v};
  endfunction : sx15
  // End-around carry; a second carry cannot arise
  function automatic logic [23:0] oca(input logic [23:0] a, b);
    logic [24:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[23:0] + {23'h0, s[24]};
  endfunction : oca
  // Signed order; plus zero sits above minus zero
  function automatic logic ges(input logic [23:0] a, b);
    return (a[23] != b[23]) ? !a[23] : a >= b;
  endfunction : ges

  task chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // ****************************************
  // Bus wrappers
  // ****************************************
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    seq.xfer(1'b1, a, d, q, e);
  endtask : wr
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    seq.xfer(1'b0, a, 32'h0, q, e);
    chk(nm, q, x);
  endtask : rdc
  task load;
    wr(OFF_PADR, {17'h0, rp});
    wr(OFF_ACC, {8'h0, ra});
    wr(OFF_AUX, {8'h0, rq});
    for (int i = 1; i < 4; i++) wr(OFF_IDX1 + 8'(4 * i - 4), {17'h0, rx[i]});
  endtask : load
  task cmp_all;
    rdc("p", OFF_PADR, {17'h0, rp});
    rdc("acc", OFF_ACC, {8'h0, ra});
    rdc("aux", OFF_AUX, {8'h0, rq});
    for (int i = 1; i < 4; i++) begin
      rdc("idx", OFF_IDX1 + 8'(4 * i - 4), {17'h0, rx[i]});
    end
  endtask : cmp_all

  // Predict, execute, compare one instruction
  task run(input logic [23:0] iw);
    logic [2:0]  s;
    logic [14:0] v15;
    logic [23:0] cur, imm, v;
    logic [31:0] q;
    logic        e, sk;
    s   = iw[SUB_HI:SUB_LO];
    v15 = iw[IMM_HI:0];
    sk  = 1'b0;
    cur = s[2] ? (s[0] ? rq : ra) : (s[1:0] != 2'h0 ? {9'h0, rx[s[1:0]]} : 24'h0);
    imm = (s[2] && s[1]) ? {9'h0, v15} : sx15(v15);
    v   = imm;
    if (iw[OPC_HI:OPC_LO] == OP_INCR) v = oca(s[2] ? cur : sx15(cur[14:0]), imm);
    case (iw[OPC_HI:OPC_LO])
      OP_ENTR, OP_INCR: begin
        if (s[2] && s[0]) rq = v;
        else if (s[2]) ra = v;
        else if (s[1:0] != 2'h0) rx[s[1:0]] = v[14:0];
      end
      OP_EQSK: sk = (s[2] && !s[1]) ? cur == imm : cur[14:0] == v15;
      OP_GESK: sk = (s[2] && !s[1]) ? ges(cur, imm) : cur[14:0] >= v15;
      OP_CHAD: ra = {{7{iw[CHA_SIGN] & s[2]}}, iw[CHA_HI:0]};
      default: ;
    endcase
    rp = rp + (sk ? 15'h2 : 15'h1);
    wr(OFF_INSTR, {8'h0, iw});
    cmp_all;
    seq.xfer(1'b0, OFF_STAT, 32'h0, q, e);
    chk("skip", {31'h0, q[STAT_SKIP_BIT]}, {31'h0, sk});
    if (iw[OPC_HI:OPC_LO] == OP_SHSK) begin
      chk("unsup", {31'h0, q[STAT_UNSUP_BIT]}, 32'h1);
    end
  endtask : run

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] q;
    logic        e;
    seed = 32'h88F9;
    failures = 0;
    n_compared = 0;
    ra = 24'h0;
    rq = 24'h0;
    rp = 15'h0;
    rx = '{15'h0, 15'h0, 15'h0};
    ops = '{OP_ENTR, OP_INCR, OP_EQSK, OP_GESK, OP_CHAD, OP_SHSK};
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp_all;
    seq.xfer(1'b0, 8'h24, 32'h0, q, e);
    chk("err", {31'h0, e}, 32'h1);
    chk("bad", q, 32'h0);
    rdc("instr", OFF_INSTR, 32'h0);
    // Random states, with equal and signed-zero corners
    for (int it = 0; it < 6; it++) begin
      y = 15'($random(seed));
      if (it % 3 == 2) y = 15'h7FFF;
      for (int o = 0; o < 6; o++) begin
        for (int s = 0; s < 8; s++) begin
          rp = 15'($random(seed));
          ra = 24'($random(seed));
          rq = 24'($random(seed));
          for (int i = 1; i < 4; i++) rx[i] = (it % 3 == 1) ? y : 15'($random(seed));
          if (it % 3 == 1) begin
            ra = sx15(y);
            rq = {9'h0, y};
          end
          if (it % 3 == 2) begin
            ra = 24'h0;
            rq = 24'hFFFFFF;
          end
          load;
          run({ops[o], 3'(s), y});
        end
      end
    end
    // Halt, unconditional stop, selective stop off and on
    for (int k = 0; k < 4; k++) begin
      y  = 15'($random(seed));
      rp = 15'($random(seed));
      load;
      if (k == 0) w = {OP_HALT, SUB_ZERO, y};
      else if (k == 1) w = {OP_MISC, STOP_UNC, 12'h0};
      else w = {OP_MISC, STOP_SEL, 12'h0};
      wr(OFF_CTRL, {31'h0, k == 3});
      wr(OFF_INSTR, {8'h0, w});
      chk("halted", {31'h0, halted}, {31'h0, k != 2});
      rp = (k == 0) ? y : rp + 15'h1;
      // Writes while stopped must not execute
      if (k != 2) wr(OFF_INSTR, {8'h0, OP_ENTR, SUB_ACCU, ~y});
      cmp_all;
      wr(OFF_CTRL, 32'h2);
      chk("resumed", {31'h0, halted}, 32'h0);
    end
    wrap_up();
  end
endmodule : test_halt_enter_increase_skip_exec

// *** core/hesx_exec.sv ***
`timescale 1ns/1ns
module hesx_exec
  import hesx_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Run state
  output logic             halted
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [31:0] prdata_ff;       // Read data
  logic        pready_ff;       // Access-phase ready
  logic        pslverr_ff;      // Unmapped address
  logic        halted_ff;       // Execution stopped
  logic        sel_stop_ff;     // Console switch copy
  logic        skip_ff;         // Last exit was P+2
  logic        unsup_ff;        // Last code not handled
  logic [14:0] p_ff;            // Execution address
  logic [23:0] acc_ff;          // Accumulator
  logic [23:0] aux_ff;          // Q register
  logic [14:0] idx_ff [1:3];    // Index registers
  logic        access;          // Completing access
  logic        wr_en;           // Completing write
  logic        exec_en;         // Instruction accepted
  logic [31:0] rd_mux;          // Read selection
  logic        rd_hit;          // Address mapped
  logic [5:0]  opc;             // Operation field
  logic [2:0]  sub;             // Sub-field
  logic [1:0]  bsel;            // Index designator
  logic [14:0] imm;             // 15-bit immediate
  logic [16:0] cha;             // 17-bit immediate
  logic [23:0] imm_sx;          // Immediate, sign extended
  logic [23:0] imm_zx;          // Immediate, zero extended
  logic [14:0] idx_rd;          // Selected index or zero
  logic [23:0] add_a;           // Adder operand A
  logic [23:0] add_b;           // Adder operand B
  logic [23:0] add_s;           // Adder result
  logic [23:0] cmp_x;           // Register compared
  logic [23:0] cmp_y;           // Immediate compared
  logic        cmp_eq;          // Equal
  logic        cmp_ge;          // Greater or equal
  logic        nxt_halted;
  logic        nxt_skip;
  logic        nxt_unsup;
  logic [14:0] nxt_p;
  logic [23:0] nxt_acc;
  logic [23:0] nxt_aux;
  logic        nxt_idx_we;      // Index write
  logic [14:0] nxt_idx;

  // ****************************************
  // Instruction fields
  // ****************************************
  // Executed straight from the write data
  assign opc  = pwdata[OPC_HI:OPC_LO];
  assign sub  = pwdata[SUB_HI:SUB_LO];
  assign bsel = pwdata[SUB_LO+1:SUB_LO];
  assign imm  = pwdata[IMM_HI:0];
  assign cha  = pwdata[CHA_HI:0];
  // Sign taken from the top immediate bit
  assign imm_sx = {{9{pwdata[IMM_SIGN]}}, imm};
  assign imm_zx = {9'h000, imm};

  // Index 0 reads as zero
  assign idx_rd = (bsel == 2'h0) ? 15'h0000 : idx_ff[bsel];

  // ****************************************
  // APB handshake
  // ****************************************
  assign access  = psel & penable & pready_ff;
  assign wr_en   = access & pwrite;
  // Instructions are refused while halted
  assign exec_en = wr_en & (paddr == OFF_INSTR) & ~halted_ff;

  // Ready one cycle after setup, so every access takes 2 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= psel & ~penable;
    end
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (psel & ~penable) begin
      prdata_ff  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr_ff <= ~rd_hit;
    end else if (!psel) begin
      pslverr_ff <= 1'b0;
    end
  end

  // Read decode
  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    unique case (paddr)
      OFF_CTRL: begin
        rd_mux[CTRL_SEL_STOP_BIT] = sel_stop_ff;
      end
      OFF_STAT: begin
        rd_mux[STAT_HALT_BIT]  = halted_ff;
        rd_mux[STAT_SKIP_BIT]  = skip_ff;
        rd_mux[STAT_UNSUP_BIT] = unsup_ff;
      end
      OFF_INSTR: rd_mux = 32'h00000000; // Write only
      OFF_PADR:  rd_mux = {17'h00000, p_ff};
      OFF_ACC:   rd_mux = {8'h00, acc_ff};
      OFF_AUX:   rd_mux = {8'h00, aux_ff};
      OFF_IDX1:  rd_mux = {17'h00000, idx_ff[1]};
      OFF_IDX2:  rd_mux = {17'h00000, idx_ff[2]};
      OFF_IDX3:  rd_mux = {17'h00000, idx_ff[3]};
      default:   rd_hit = 1'b0;
    endcase
  end

  // ****************************************
  // Shared one's-complement adder
  // ****************************************
  // Operand choice: sub-field picks register and extension
  always_comb begin
    add_a = {{9{idx_rd[14]}}, idx_rd};
    add_b = imm_sx;
    unique case (sub)
      SUB_ACCU: begin
        add_a = acc_ff;
        add_b = imm_zx;
      end
      SUB_ACCS: add_a = acc_ff;
      SUB_AUXU: begin
        add_a = aux_ff;
        add_b = imm_zx;
      end
      SUB_AUXS: add_a = aux_ff;
      default: ;
    endcase
  end

  hesx_oc_add u_add (
    .opa (add_a),
    .opb (add_b),
    .sum (add_s)
  );

  // ****************************************
  // Skip comparison
  // ****************************************
  // Unsigned forms use the low 15 bits only
  always_comb begin
    cmp_x = {9'h000, idx_rd};
    cmp_y = imm_zx;
    unique case (sub)
      SUB_ACCU: cmp_x = {9'h000, acc_ff[14:0]};
      SUB_ACCS: begin
        cmp_x = acc_ff;
        cmp_y = imm_sx;
      end
      SUB_AUXU: cmp_x = {9'h000, aux_ff[14:0]};
      SUB_AUXS: begin
        cmp_x = aux_ff;
        cmp_y = imm_sx;
      end
      default: ;
    endcase
  end

  // Bitwise equality: plus and minus zero differ here on purpose
  assign cmp_eq = (cmp_x == cmp_y);

  // Signed order: sign differs, plus side wins (+0 above -0);
  // same sign, raw bits order correctly in one's complement
  always_comb begin
    if ((sub == SUB_ACCS) || (sub == SUB_AUXS)) begin
      if (cmp_x[23] != cmp_y[23]) begin
        cmp_ge = ~cmp_x[23];
      end else begin
        cmp_ge = (cmp_x >= cmp_y);
      end
    end else begin
      cmp_ge = (cmp_x >= cmp_y);
    end
  end

  // ****************************************
  // Execution decode
  // ****************************************
  always_comb begin
    nxt_halted = halted_ff;
    nxt_skip   = 1'b0;
    nxt_unsup  = 1'b0;
    nxt_p      = p_ff + 15'h0001;
    nxt_acc    = acc_ff;
    nxt_aux    = aux_ff;
    nxt_idx_we = 1'b0;
    nxt_idx    = imm;
    unique case (opc)
      OP_HALT: begin
        if (sub == SUB_ZERO) begin
          // Address field used as is, never modified
          nxt_halted = 1'b1;
          nxt_p      = imm;
        end else begin
          nxt_unsup = 1'b1;
        end
      end
      OP_MISC: begin
        if (pwdata[STOP_HI:STOP_LO] == STOP_SEL) begin
          nxt_halted = sel_stop_ff;
        end else if (pwdata[STOP_HI:STOP_LO] == STOP_UNC) begin
          nxt_halted = 1'b1;
        end else begin
          nxt_unsup = 1'b1;
        end
      end
      OP_ENTR: begin
        unique case (sub)
          SUB_ACCU: nxt_acc = imm_zx;
          SUB_ACCS: nxt_acc = imm_sx;
          SUB_AUXU: nxt_aux = imm_zx;
          SUB_AUXS: nxt_aux = imm_sx;
          default: begin
            if (sub[2]) begin
              nxt_unsup = 1'b1;
            end else begin
              nxt_idx_we = (bsel != 2'h0);
              nxt_idx    = imm;
            end
          end
        endcase
      end
      OP_CHAD: begin
        if (sub[2]) begin
          nxt_acc = {{7{cha[CHA_SIGN]}}, cha};
        end else begin
          nxt_acc = {7'h00, cha};
        end
      end
      OP_INCR: begin
        unique case (sub)
          SUB_ACCU, SUB_ACCS: nxt_acc = add_s;
          SUB_AUXU, SUB_AUXS: nxt_aux = add_s;
          default: begin
            if (sub[2]) begin
              nxt_unsup = 1'b1;
            end else begin
              // Upper sum bits dropped on the way back
              nxt_idx_we = (bsel != 2'h0);
              nxt_idx    = add_s[14:0];
            end
          end
        endcase
      end
      OP_EQSK, OP_GESK: begin
        // Every sub code is legal: 0-3 index b, 4-7 A or Q
        if ((opc == OP_EQSK) ? cmp_eq : cmp_ge) begin
          nxt_skip = 1'b1;
          nxt_p    = p_ff + 15'h0002;
        end
      end
      OP_SHSK: begin
        // Storage shift and index skips are handled elsewhere;
        // sub 0 is never taken for an index skip
        nxt_unsup = 1'b1;
      end
      default: nxt_unsup = 1'b1;
    endcase
  end

  // ****************************************
  // State registers
  // ****************************************
  // Console switch and halt; restart only clears a halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_stop_ff <= 1'b0;
      halted_ff   <= 1'b0;
    end else if (wr_en && (paddr == OFF_CTRL)) begin
      sel_stop_ff <= pwdata[CTRL_SEL_STOP_BIT];
      if (pwdata[CTRL_RESTART_BIT]) begin
        halted_ff <= 1'b0;
      end
    end else if (exec_en) begin
      halted_ff <= nxt_halted;
    end
  end

  // Exit status of the last instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_ff  <= 1'b0;
      unsup_ff <= 1'b0;
    end else if (exec_en) begin
      skip_ff  <= nxt_skip;
      unsup_ff <= nxt_unsup;
    end
  end

  // Execution address: software load or instruction exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_ff <= RST_ADDR;
    end else if (wr_en && (paddr == OFF_PADR)) begin
      p_ff <= pwdata[14:0];
    end else if (exec_en) begin
      p_ff <= nxt_p;
    end
  end

  // Accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= RST_WORD;
    end else if (wr_en && (paddr == OFF_ACC)) begin
      acc_ff <= pwdata[23:0];
    end else if (exec_en) begin
      acc_ff <= nxt_acc;
    end
  end

  // Q register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_ff <= RST_WORD;
    end else if (wr_en && (paddr == OFF_AUX)) begin
      aux_ff <= pwdata[23:0];
    end else if (exec_en) begin
      aux_ff <= nxt_aux;
    end
  end

  // Index registers; one generate copy each
  for (genvar gi = 1; gi <= 3; gi++) begin : g_idx
    localparam logic [7:0] OFF = OFF_IDX1 + 8'(4 * (gi - 1));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        idx_ff[gi] <= RST_ADDR;
      end else if (wr_en && (paddr == OFF)) begin
        idx_ff[gi] <= pwdata[14:0];
      end else if (exec_en && nxt_idx_we && (bsel == 2'(gi))) begin
        idx_ff[gi] <= nxt_idx;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign halted  = halted_ff;

endmodule : hesx_exec

// *** core/hesx_oc_add.sv ***
`timescale 1ns/1ns
// ****************************************
// 24-bit one's-complement adder
// ****************************************
module hesx_oc_add (
  // Operands
  input  wire logic [23:0] opa,
  input  wire logic [23:0] opb,
  // Result
  output logic      [23:0] sum
);
  logic [24:0] raw; // Sum with carry out

  // Plain binary sum first
  assign raw = {1'b0, opa} + {1'b0, opb};
  // End-around carry; a second carry cannot arise
  assign sum = raw[23:0] + {23'h000000, raw[24]};
endmodule : hesx_oc_add

// *** core/hesx_pkg.sv ***
package hesx_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_CTRL  = 8'h00; // Console and restart
  localparam logic [7:0] OFF_STAT  = 8'h04; // Run state
  localparam logic [7:0] OFF_INSTR = 8'h08; // Instruction to execute
  localparam logic [7:0] OFF_PADR  = 8'h0C; // Execution address P
  localparam logic [7:0] OFF_ACC   = 8'h10; // Accumulator
  localparam logic [7:0] OFF_AUX   = 8'h14; // Q register
  localparam logic [7:0] OFF_IDX1  = 8'h18; // Index register 1
  localparam logic [7:0] OFF_IDX2  = 8'h1C; // Index register 2
  localparam logic [7:0] OFF_IDX3  = 8'h20; // Index register 3

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_SEL_STOP_BIT = 0; // Selective-stop switch
  localparam int CTRL_RESTART_BIT  = 1; // Write 1 to restart
  localparam int STAT_HALT_BIT     = 0; // Halted
  localparam int STAT_SKIP_BIT     = 1; // Last exit was P+2
  localparam int STAT_UNSUP_BIT    = 2; // Last code not executed here
  localparam int OPC_HI            = 23; // Operation field
  localparam int OPC_LO            = 18;
  localparam int SUB_HI            = 17; // Sub-field
  localparam int SUB_LO            = 15;
  localparam int IMM_HI            = 14; // 15-bit immediate
  localparam int IMM_SIGN          = 14; // Sign of 15-bit immediate
  localparam int CHA_HI            = 16; // 17-bit immediate
  localparam int CHA_SIGN          = 16; // Sign of 17-bit immediate
  localparam int STOP_HI           = 17; // Stop code field of op 77
  localparam int STOP_LO           = 12;

  // ****************************************
  // Operation and sub-field codes
  // ****************************************
  localparam logic [5:0] OP_HALT  = 6'h00;
  localparam logic [5:0] OP_EQSK  = 6'h04;
  localparam logic [5:0] OP_GESK  = 6'h05;
  localparam logic [5:0] OP_SHSK  = 6'h08; // Octal 10
  localparam logic [5:0] OP_CHAD  = 6'h09; // Octal 11
  localparam logic [5:0] OP_ENTR  = 6'h0C; // Octal 14
  localparam logic [5:0] OP_INCR  = 6'h0D; // Octal 15
  localparam logic [5:0] OP_MISC  = 6'h3F; // Octal 77
  localparam logic [2:0] SUB_ACCU = 3'h6;
  localparam logic [2:0] SUB_ACCS = 3'h4;
  localparam logic [2:0] SUB_AUXU = 3'h7;
  localparam logic [2:0] SUB_AUXS = 3'h5;
  localparam logic [2:0] SUB_ZERO = 3'h0;
  localparam logic [5:0] STOP_SEL = 6'h3E; // Selective stop code
  localparam logic [5:0] STOP_UNC = 6'h3D; // Unconditional stop code

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [23:0] RST_WORD = 24'h000000;
  localparam logic [14:0] RST_ADDR = 15'h0000;

endpackage : hesx_pkg
